// ### hw/dpio_defines.vh
// constants for the two-port pin function block
`ifndef DPIO_DEFINES_VH
`define DPIO_DEFINES_VH

// ------------------------------------------------------------
// register word index (byte address is index times four)
// ------------------------------------------------------------
`define DPIO_IDX_DIR_A      3'd0
`define DPIO_IDX_DATA_A     3'd1
`define DPIO_IDX_FSEL_A     3'd2
`define DPIO_IDX_PULLUP_A   3'd3
`define DPIO_IDX_DIR_B      3'd4
`define DPIO_IDX_DATA_B     3'd5
`define DPIO_IDX_SBUS_CTRL  3'd6
`define DPIO_IDX_TIMER_SEL  3'd7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DPIO_FSEL_OD7       7
`define DPIO_FSEL_OD6       6
`define DPIO_SBUS_ON_BIT    0
`define DPIO_TS_DIS_D       0
`define DPIO_TS_DIS_C       1
`define DPIO_TS_COMBO_HI    3
`define DPIO_TS_COMBO_LO    2
`define DPIO_TS_PWM_D       4
`define DPIO_TS_PWM_C       5
`define DPIO_TS_IOD_HI      8
`define DPIO_TS_IOD_LO      6
`define DPIO_TS_IOC_HI      11
`define DPIO_TS_IOC_LO      9
`define DPIO_PULLUP_MASK    8'h3f

// ------------------------------------------------------------
// reset values and fixed answers
// ------------------------------------------------------------
`define DPIO_RST_BYTE       8'h00
`define DPIO_RST_TIMER_SEL  12'h003
`define DPIO_WO_READ        32'h0000_0000
`define DPIO_RESP_OKAY      2'b00
`define DPIO_RESP_SLVERR    2'b10

`endif

// ### hw/dpio_pin_cell.v
// one pin: general or alternate drive, open drain and pull-up
`timescale 1ns/1ps
`default_nettype none
module dpio_pin_cell (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire dir,
  input  wire data,
  input  wire od_sel,
  input  wire alt_on,
  input  wire alt_drive,
  input  wire alt_od,
  input  wire alt_data,
  input  wire pullup_req,
  output reg  pin_out,
  output reg  pin_oe,
  output reg  pullup_on
);
  wire drive_w;
  wire val_w;
  wire od_w;

  // alternate function overrides direction and data
  assign drive_w = alt_on ? alt_drive : dir;
  assign val_w   = alt_on ? alt_data : data;
  assign od_w    = alt_on ? alt_od : od_sel;

  // registered pad controls; open drain only ever pulls low
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      pullup_on <= 1'b0;
    end else begin
      pin_out   <= od_w ? 1'b0 : val_w;
      pin_oe    <= drive_w & (~od_w | ~val_w);
      pullup_on <= pullup_req & ~alt_on & ~dir;
    end
  end
endmodule // dpio_pin_cell
`default_nettype wire

// ### hw/dpio_top.v
// two 8-bit pin ports with alternate functions behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "dpio_defines.vh"
module dpio_top #(
  parameter ADDR_W = 12
) (
  input  wire              sys_clk,
  input  wire              sys_rst,
  // axi4-lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // port a pads
  input  wire [7:0]        pa_in,
  output wire [7:0]        pa_out,
  output wire [7:0]        pa_oe,
  output wire [7:0]        pa_pullup,
  // port b pads
  input  wire [7:0]        pb_in,
  output wire [7:0]        pb_out,
  output wire [7:0]        pb_oe,
  // serial bus unit: drive values 0 pull the line low
  input  wire              sbus_clk_drive,
  input  wire              sbus_data_drive,
  output reg               sbus_clk_in,
  output reg               sbus_data_in,
  // wake-up and converter trigger
  output reg  [5:0]        wakeup_in,
  output reg               converter_trigger_in,
  // timer channel lines and the serial bus enable status
  input  wire              timer_line_d_ch1_out,
  input  wire              timer_line_c_ch1_out,
  output reg               timer_line_d_ch1_in,
  output reg               timer_line_c_ch1_in,
  output reg               sbus_iface_on_out
);

  // ------------------------------------------------------------
  // register map, one 32-bit word each, low byte used except timer select (12 bits)
  // ------------------------------------------------------------
  // 0x00 port-a direction, write-only, reads as zero
  // 0x04 port-a data: stored bit if output, live pin if input
  // 0x08 port-a function select: 7,6 open drain, 5..0 wake-up
  // 0x0c port-a pull-up enable, bits 5..0; bits 7,6 read zero
  // 0x10 port-b direction, write-only, reads as zero
  // 0x14 port-b data: stored bit if output, live pin if input
  // 0x18 serial bus control, bit 0 hands pins 7,6 to the bus
  // 0x1c timer select, needs byte lanes 0 and 1:
  //      bit 0 / 1   output disable, channel d / c
  //      bits 3:2    combination mode
  //      bit 4 / 5   pwm select, channel d / c
  //      bits 8:6    i/o control, channel d
  //      bits 11:9   i/o control, channel c
  // unmapped words answer slverr and reads return zero
  //
  // limitations: every register change reaches the pads one
  // clock later, because each pad control is registered so
  // the pads never see decode glitches; the serial bus and
  // wake-up lines take the raw pad level, so the units behind
  // them must filter glitches themselves
  //
  // data reads follow the direction bit only, not ownership:
  // a pin lent to a unit still reads as its direction says

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0]        pin_direction_a_r;
  reg  [7:0]        pin_output_data_a_r;
  reg  [7:0]        pin_function_select_a_r;
  reg  [5:0]        input_pullup_enable_a_r;
  reg  [7:0]        pin_direction_b_r;
  reg  [7:0]        pin_output_data_b_r;
  reg               serial_bus_iface_on_r;
  reg  [11:0]       timer_sel_r;

  reg  [ADDR_W-1:0] aw_addr_r;
  reg  [31:0]       wdata_r;
  reg  [3:0]        wstrb_r;
  reg               aw_got_r;
  reg               w_got_r;

  wire              wr_fire;
  wire              wr_hit;
  wire [2:0]        wr_idx;
  wire              rd_hit;
  wire [2:0]        rd_idx;
  reg  [31:0]       rd_nxt;

  // word decode; anything at or above 0x20 is unmapped
  assign wr_idx  = aw_addr_r[4:2];
  assign wr_hit  = (aw_addr_r[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});
  assign rd_idx  = s_axi_araddr[4:2];
  assign rd_hit  = (s_axi_araddr[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});
  assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;

  // ------------------------------------------------------------
  // axi write channel: address and data taken in any order
  // ------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DPIO_RESP_OKAY;
      aw_addr_r     <= {ADDR_W{1'b0}};
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
      // one write at a time: ready again only after the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // register writes, byte lane 0 (and lane 1 for timer select)
  // ------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_direction_a_r       <= `DPIO_RST_BYTE;
      pin_output_data_a_r     <= `DPIO_RST_BYTE;
      pin_function_select_a_r <= `DPIO_RST_BYTE;
      input_pullup_enable_a_r <= 6'h00;
      pin_direction_b_r       <= `DPIO_RST_BYTE;
      pin_output_data_b_r     <= `DPIO_RST_BYTE;
      serial_bus_iface_on_r   <= 1'b0;
      timer_sel_r             <= `DPIO_RST_TIMER_SEL;
    end else if (wr_fire && wr_hit) begin
      if (wstrb_r[0]) begin
        case (wr_idx)
          `DPIO_IDX_DIR_A:     pin_direction_a_r       <= wdata_r[7:0];
          `DPIO_IDX_DATA_A:    pin_output_data_a_r     <= wdata_r[7:0];
          `DPIO_IDX_FSEL_A:    pin_function_select_a_r <= wdata_r[7:0];
          `DPIO_IDX_PULLUP_A:  input_pullup_enable_a_r <= wdata_r[5:0];
          `DPIO_IDX_DIR_B:     pin_direction_b_r       <= wdata_r[7:0];
          `DPIO_IDX_DATA_B:    pin_output_data_b_r     <= wdata_r[7:0];
          `DPIO_IDX_SBUS_CTRL: serial_bus_iface_on_r   <= wdata_r[`DPIO_SBUS_ON_BIT];
          `DPIO_IDX_TIMER_SEL: timer_sel_r[7:0]        <= wdata_r[7:0];
          default: begin
          end
        endcase
      end
      if (wstrb_r[1] && wr_idx == `DPIO_IDX_TIMER_SEL) begin
        timer_sel_r[11:8] <= wdata_r[11:8];
      end
    end
  end

  // ------------------------------------------------------------
  // read data selection
  // ------------------------------------------------------------
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (rd_idx)
      `DPIO_IDX_DIR_A:     rd_nxt = `DPIO_WO_READ;
      `DPIO_IDX_DATA_A:    rd_nxt = {24'h000000, (pin_direction_a_r & pin_output_data_a_r) |
                                                 (~pin_direction_a_r & pa_in)};
      `DPIO_IDX_FSEL_A:    rd_nxt = {24'h000000, pin_function_select_a_r};
      `DPIO_IDX_PULLUP_A:  rd_nxt = {26'h0000000, input_pullup_enable_a_r};
      `DPIO_IDX_DIR_B:     rd_nxt = `DPIO_WO_READ;
      `DPIO_IDX_DATA_B:    rd_nxt = {24'h000000, (pin_direction_b_r & pin_output_data_b_r) |
                                                 (~pin_direction_b_r & pb_in)};
      `DPIO_IDX_SBUS_CTRL: rd_nxt = {31'h00000000, serial_bus_iface_on_r};
      `DPIO_IDX_TIMER_SEL: rd_nxt = {20'h00000, timer_sel_r};
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // axi read channel: answer one cycle after the address is taken
  // ------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DPIO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_hit ? rd_nxt : 32'h0000_0000;
        s_axi_rresp   <= rd_hit ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // timer ownership of port-b pins 7 and 6
  // ------------------------------------------------------------
  wire       combo_zero;
  wire [2:0] io_d;
  wire [2:0] io_c;
  wire       timer_owns_d;
  wire       timer_owns_c;

  assign combo_zero = (timer_sel_r[`DPIO_TS_COMBO_HI:`DPIO_TS_COMBO_LO] == 2'b00);
  assign io_d       = timer_sel_r[`DPIO_TS_IOD_HI:`DPIO_TS_IOD_LO];
  assign io_c       = timer_sel_r[`DPIO_TS_IOC_HI:`DPIO_TS_IOC_LO];

  // timer drives the pin when its disable bit (0 for d, 1 for c) is clear and its mode drives output
  assign timer_owns_d = ~timer_sel_r[`DPIO_TS_DIS_D] &
                        ((combo_zero & ~timer_sel_r[`DPIO_TS_PWM_D] &
                          (io_d == 3'b001 || io_d[2:1] == 2'b01)) |
                         timer_sel_r[`DPIO_TS_PWM_D] | ~combo_zero);
  assign timer_owns_c = ~timer_sel_r[`DPIO_TS_DIS_C] &
                        ((combo_zero & ~timer_sel_r[`DPIO_TS_PWM_C] &
                          (io_c == 3'b001 || io_c[2:1] == 2'b01)) |
                         timer_sel_r[`DPIO_TS_PWM_C] | ~combo_zero);

  // ------------------------------------------------------------
  // alternate-function selection per pin
  // ------------------------------------------------------------
  wire [7:0] a_alt_on;
  wire [7:0] a_alt_drive;
  wire [7:0] a_alt_data;
  wire [7:0] b_alt_on;
  wire [7:0] b_alt_data;

  // serial bus takes pins 7 and 6 as open drain
  // wake-up select turns pins 5..0 into plain inputs
  assign a_alt_on    = {{2{serial_bus_iface_on_r}}, pin_function_select_a_r[5:0]};
  assign a_alt_drive = {2'b11, 6'h00};
  assign a_alt_data  = {sbus_clk_drive, sbus_data_drive, 6'h00};
  // without timer ownership the pin stays a general port pin
  assign b_alt_on    = {timer_owns_d, timer_owns_c, 6'h00};
  assign b_alt_data  = {timer_line_d_ch1_out, timer_line_c_ch1_out, 6'h00};

  // ------------------------------------------------------------
  // pin cells
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      dpio_pin_cell u_a (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .dir        (pin_direction_a_r[gi]),
        .data       (pin_output_data_a_r[gi]),
        .od_sel     ((gi >= 6) ? pin_function_select_a_r[gi] : 1'b0),
        .alt_on     (a_alt_on[gi]),
        .alt_drive  (a_alt_drive[gi]),
        .alt_od     (1'b1),
        .alt_data   (a_alt_data[gi]),
        .pullup_req ((gi < 6) ? input_pullup_enable_a_r[gi % 6] : 1'b0),
        .pin_out    (pa_out[gi]),
        .pin_oe     (pa_oe[gi]),
        .pullup_on  (pa_pullup[gi])
      );
      // port-b pin, timer lines are push-pull
      dpio_pin_cell u_b (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .dir        (pin_direction_b_r[gi]),
        .data       (pin_output_data_b_r[gi]),
        .od_sel     (1'b0),
        .alt_on     (b_alt_on[gi]),
        .alt_drive  (1'b1),
        .alt_od     (1'b0),
        .alt_data   (b_alt_data[gi]),
        .pullup_req (1'b0),
        .pin_out    (pb_out[gi]),
        .pin_oe     (pb_oe[gi]),
        .pullup_on  ()
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // inputs handed to the other units, registered
  // ------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sbus_clk_in          <= 1'b1;
      sbus_data_in         <= 1'b1;
      wakeup_in            <= 6'h00;
      converter_trigger_in <= 1'b0;
      timer_line_d_ch1_in  <= 1'b0;
      timer_line_c_ch1_in  <= 1'b0;
      sbus_iface_on_out    <= 1'b0;
    end else begin
      // idle-high bus lines when the serial unit does not own the pins
      sbus_clk_in          <= serial_bus_iface_on_r ? pa_in[7] : 1'b1;
      sbus_data_in         <= serial_bus_iface_on_r ? pa_in[6] : 1'b1;
      wakeup_in            <= pa_in[5:0] & pin_function_select_a_r[5:0];
      converter_trigger_in <= pa_in[5] & pin_function_select_a_r[5];
      // capture sees the pin while general
      timer_line_d_ch1_in  <= pb_in[7] & ~timer_owns_d;
      timer_line_c_ch1_in  <= pb_in[6] & ~timer_owns_c;
      sbus_iface_on_out    <= serial_bus_iface_on_r;
    end
  end

endmodule // dpio_top
`default_nettype wire

// ### verif/dpio_pad_model.sv
// pad model: outside circuits on both ports, with pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module dpio_pad_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pullup,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] ext_a_en,
  input  wire logic [7:0] ext_a_val,
  input  wire logic [7:0] ext_b_en,
  input  wire logic [7:0] ext_b_val,
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in
);
  logic float_r;
  // an undriven line wanders each cycle, so a stale level never reads as valid
  initial float_r = 1'b0;
  always @(posedge sys_clk) float_r <= ~float_r;
  // pin drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = pa_oe[i] ? pa_out[i] : ext_a_en[i] ? ext_a_val[i] : pa_pullup[i] ? 1'b1 : float_r;
      pb_in[i] = pb_oe[i] ? pb_out[i] : ext_b_en[i] ? ext_b_val[i] : float_r;
    end
  end
endmodule // dpio_pad_model
`default_nettype wire

// ### verif/dpio_top_monitor.sv
// assertion checker for the two-port pin block
`timescale 1ns/1ps
`default_nettype none
module dpio_top_monitor #(
  parameter ADDR_W = 12
) (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [7:0]        pa_out,
  input wire logic [7:0]        pa_oe,
  input wire logic [7:0]        pa_pullup,
  input wire logic              sbus_clk_drive,
  input wire logic [5:0]        wakeup_in,
  input wire logic              converter_trigger_in,
  input wire logic              sbus_iface_on_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // write taken whole at one edge
  sequence seq_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read taken beyond the register map
  sequence seq_rd_bad;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr >= 'h20);
  endsequence
  chk_pullup_rsvd: assert property (pa_pullup[7:6] == 2'b00)
    else $error("pull-up on a reserved pin");
  chk_pullup_input: assert property ((pa_pullup & pa_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  chk_sbus_clk_od: assert property (sbus_iface_on_out && $past(sbus_iface_on_out) |->
    pa_oe[7] == !$past(sbus_clk_drive) && !(pa_oe[7] && pa_out[7]))
    else $error("serial clock pin not open drain");
  chk_wake_trigger: assert property (converter_trigger_in == wakeup_in[5])
    else $error("trigger differs from wake-up pin 5");
  chk_wr_answer: assert property (seq_wr_both |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rd_unmapped: assert property (seq_rd_bad |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready)
    else $error("read data dropped");
  chk_dir_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:5] == 0
    && s_axi_araddr[3:0] == 4'h0 && !s_axi_araddr[2] |=> s_axi_rdata == 32'h0)
    else $error("direction register read not fixed");
endmodule // dpio_top_monitor
bind dpio_top dpio_top_monitor #(.ADDR_W(ADDR_W)) i_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pa_out(pa_out), .pa_oe(pa_oe),
  .pa_pullup(pa_pullup), .sbus_clk_drive(sbus_clk_drive), .wakeup_in(wakeup_in),
  .converter_trigger_in(converter_trigger_in), .sbus_iface_on_out(sbus_iface_on_out));
`default_nettype wire

// ### verif/dpio_bench.sv
// self-checking bench for the two-port pin block
`timescale 1ns/1ps
`default_nettype none
`include "dpio_defines.vh"
module dpio_bench;
  logic        sys_clk, sys_rst, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe, xa_en, xa_v, xb_en, xb_v;
  logic        clk_drv, dat_drv, clk_in, dat_in, bus_on, trig, d_out, c_out, d_in, c_in;
  logic [5:0]  wake;
  int          err_count, num_checks;
  dpio_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .sbus_clk_drive(clk_drv), .sbus_data_drive(dat_drv), .sbus_clk_in(clk_in),
    .sbus_data_in(dat_in), .wakeup_in(wake), .converter_trigger_in(trig), .timer_line_d_ch1_out(d_out),
    .timer_line_c_ch1_out(c_out), .timer_line_d_ch1_in(d_in), .timer_line_c_ch1_in(c_in),
    .sbus_iface_on_out(bus_on));
  dpio_pad_model i_pads (.sys_clk(sys_clk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu),
    .pb_out(pb_out), .pb_oe(pb_oe), .ext_a_en(xa_en), .ext_a_val(xa_v), .ext_b_en(xb_en),
    .ext_b_val(xb_v), .pa_in(pa_in), .pb_in(pb_in));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write one word; readies sampled at the edge, bready raised once bvalid is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv && !br) br <= 1'b1;
    end while (!(bv && br) && n < 50);
    if (!(bv && br)) begin
      err_count++;
      stop_test();
    end
    br <= 1'b0;
    rsp = bresp;
  endtask
  // read one word; rready raised late so the held answer is exercised
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv && !rr) rr <= 1'b1;
    end while (!(rv && rr) && n < 50);
    if (!(rv && rr)) begin
      err_count++;
      stop_test();
    end
    rr <= 1'b0;
    rd = rdat;
    rsp = rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdr(a);
    check("read data", rd, e);
  endtask
  // pad outputs lag one edge; give them room, then sample off the edge
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task t_reset;
    rchk(12'h00c, 32'h0);
    rchk(12'h010, `DPIO_WO_READ);
    check("pb_oe", pb_oe, 32'h0);
    wr(12'h010, 32'hff);
    rchk(12'h014, 32'h0);
    rchk(12'h020, 32'h0);
    check("rresp", rsp, `DPIO_RESP_SLVERR);
    wr(12'h024, 32'hff);
    check("bresp", rsp, `DPIO_RESP_SLVERR);
  endtask
  task t_port_b;
    wr(12'h010, 32'hf0);
    wr(12'h014, 32'ha5);
    xb_en <= 8'h0f;
    xb_v <= 8'h03;
    settle();
    check("pb_oe", pb_oe, 32'hf0);
    check("pb_out", pb_out & 8'hf0, 32'ha0);
    rchk(12'h014, 32'ha3);
  endtask
  task t_pullup;
    xa_en <= 8'hc0;
    xa_v <= 8'h40;
    wr(12'h000, 32'h0f);
    wr(12'h00c, 32'hff);
    wr(12'h004, 32'h05);
    settle();
    rchk(12'h00c, 32'h3f);
    check("pa_pullup", pa_pu, 32'h30);
    check("pa_oe", pa_oe, 32'h0f);
    rchk(12'h004, 32'h75);
    rchk(12'h000, `DPIO_WO_READ);
    wr(12'h00c, 32'h00);
    settle();
    check("pa_pullup", pa_pu, 32'h0);
  endtask
  task t_sbus_wake;
    @(posedge sys_clk);
    xa_en <= 8'h7f;
    xa_v <= 8'h61;
    clk_drv <= 1'b0;
    dat_drv <= 1'b1;
    // mixed directions: alternate pins must ignore them, pull-ups must stay off
    wr(12'h000, 32'h43);
    wr(12'h004, 32'hff);
    wr(12'h00c, 32'h3f);
    wr(12'h008, 32'h3f);
    wr(12'h018, 32'h01);
    settle();
    check("pa_oe", pa_oe, 32'h80);
    check("pa_out", pa_out & 8'h80, 32'h0);
    check("pa_pullup", pa_pu, 32'h0);
    check("wake", {trig, wake}, 32'h61);
    check("serial in", {clk_in, dat_in}, 32'h1);
    wr(12'h018, 32'h00);
    wr(12'h008, 32'hc0);
    wr(12'h004, 32'h40);
    wr(12'h000, 32'hff);
    settle();
    check("pa_oe", pa_oe, 32'hbf);
    check("pa_out", pa_out & 8'hc0, 32'h0);
    wr(12'h008, 32'h00);
    settle();
    check("pa_out", pa_out & 8'hc0, 32'h40);
  endtask
  task t_timer;
    logic [11:0] mode [10];
    logic [1:0]  own [10];
    mode = '{12'h003, 12'h042, 12'h082, 12'h102, 12'h012, 12'h006, 12'h004, 12'h201, 12'h021, 12'h002};
    own = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b10, 2'b10, 2'b11, 2'b01, 2'b01, 2'b00};
    @(posedge sys_clk);
    xb_en <= 8'hc0;
    xb_v <= 8'hc0;
    d_out <= 1'b1;
    c_out <= 1'b0;
    wr(12'h010, 32'h00);
    for (int i = 0; i < 10; i++) begin
      wr(12'h01c, {20'h0, mode[i]});
      settle();
      check("pb_oe", pb_oe[7:6], own[i]);
      check("pb_out", pb_out[7:6] & own[i], own[i] & 2'b10);
      check("capture", {d_in, c_in}, own[i] ^ 2'b11);
    end
  endtask
  initial begin
    {sys_rst, awv, wv, br, arv, rr, clk_drv, dat_drv} = 8'h83;
    {awa, ara, wd} = 56'h0;
    {xa_en, xa_v, xb_en, xb_v} = 32'h0;
    {d_out, c_out} = 2'b00;
    {err_count, num_checks} = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_port_b();
    t_pullup();
    t_sbus_wake();
    t_timer();
    stop_test();
  end
endmodule // dpio_bench
`default_nettype wire
